// file: hw/ulmcs_top.sv
// line format, modem control, line status and resume characters
// assumes a byte register port, rx fifo and transmitter events on clock
`include "ulmcs_params.svh"
module ulmcs_top
    import ulmcs_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       por_rst,        // power-on reset
    input  wire logic [2:0] reg_addr,       // register offset
    input  wire logic       reg_wr,         // write strobe
    input  wire logic       reg_rd,         // read strobe
    input  wire logic [7:0] reg_wdata,      // write data
    output logic      [7:0] reg_rdata,      // read data, next cycle
    input  wire logic       enh_func_en,    // enhanced_feature_reg bit 4
    input  wire logic       extra_page_sel, // extra_feature_reg bit 2
    input  wire logic       rx_char_valid,  // received character pulse
    input  wire logic [2:0] rx_char_err,    // {break, framing, parity}
    input  wire logic       rx_flow_char,   // character is a flow char
    input  wire logic       rx_swflow_en,   // receive soft flow enabled
    input  wire logic       rx_pop,         // host reads one character
    input  wire logic       thr_full,       // transmit holding occupied
    input  wire logic       tsr_busy,       // transmit shift occupied
    input  wire logic       tx_serial,      // encoder output line
    input  wire logic       rx_pin,         // receive pin
    input  wire logic       auto_rts_en,    // automatic send-request on
    input  wire logic       auto_rts_n,     // send-request from flow ctl
    input  wire logic       dtr_pin_sel,    // gpio assigned terminal-ready
    output logic            send_req_n,     // send-request pin level
    output logic            term_rdy_n,     // terminal-ready pin level
    output logic            rx_serial,      // line into decoder
    output logic            tx_resume,      // resume halted transmitter
    output logic            infrared_en,    // infrared signalling mode
    output logic            baud_en,        // baud clock enable
    output logic      [3:0] msr_loop,       // {cd, bell, dsr, cts}
    output logic            alt_sel,        // alternate registers 6/7
    output logic      [3:0] data_bits,      // data bits per character
    output logic      [2:0] stop_halves,    // stop length, half bits
    output logic      [7:0] line_stat,      // line status register
    output logic      [7:0] resume_one,     // resume character one
    output logic      [7:0] resume_two      // resume character two
);
    // ==========================================================
    // state registers
    ulmcs_state_t s_q;          // current state
    ulmcs_state_t s_d;          // next state
    ulmcs_state_t s_rst;        // reset image

    logic         div_latch;    // divisor latch hides normal page
    logic         resume_page;  // resume characters visible
    logic         loopback;     // internal loopback active
    logic         rx_accept;    // character offered to the fifo, stored only when not full
    logic         fifo_full;    // rx fifo at depth
    logic         push;         // write one character tag
    logic         pop;          // retire one character tag
    logic         lsr_read;     // host reads line status

    // ==========================================================
    // reset image
    always_comb
    begin
        s_rst             = '0;
        s_rst.line_fmt    = `ULMCS_LINE_FMT_RST;
        s_rst.modem_ctl   = `ULMCS_MODEM_CTL_RST;
        s_rst.resume_one  = `ULMCS_RESUME_RST;
        s_rst.resume_two  = `ULMCS_RESUME_RST;
        s_rst.line_stat   = `ULMCS_LINE_STAT_RST;
        s_rst.sync1       = 1'b1;
        s_rst.sync2       = 1'b1;
        s_rst.sync3       = 1'b1;
        s_rst.rx_stable   = 1'b1;
        s_rst.rx_serial   = 1'b1;
        s_rst.send_req_n  = 1'b1;
        s_rst.term_rdy_n  = 1'b1;
        s_rst.baud_en     = 1'b1;
        s_rst.data_bits   = `ULMCS_WLEN_BASE + 4'h3;
        s_rst.stop_halves = `ULMCS_STOP_ONE;
    end

    // ==========================================================
    // next-state logic
    always_comb
    begin
        s_d         = s_q;
        div_latch   = s_q.line_fmt[`ULMCS_LF_DIV_LATCH];
        resume_page = (s_q.line_fmt == `ULMCS_RESUME_KEY) && !extra_page_sel;
        loopback    = s_q.modem_ctl[`ULMCS_MC_LOOPBACK];
        fifo_full   = (s_q.count == `ULMCS_FIFO_DEPTH);
        // flow characters under soft flow control stay out of the fifo
        rx_accept   = rx_char_valid && !(rx_flow_char && rx_swflow_en);
        push        = rx_accept && !fifo_full;
        pop         = rx_pop && (s_q.count != 7'h00);
        lsr_read    = reg_rd && (reg_addr == `ULMCS_OFF_LINE_STAT) && !div_latch;

        // rx pin: three stages, a change counts when stages 2 and 3 agree
        s_d.sync1 = rx_pin;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        if (s_q.sync2 == s_q.sync3)
        begin
            s_d.rx_stable = s_q.sync3;
        end

        // register writes
        if (reg_wr)
        begin
            case (reg_addr)
                `ULMCS_OFF_LINE_FMT:
                begin
                    s_d.line_fmt = reg_wdata;
                end
                `ULMCS_OFF_MODEM_CTL:
                begin
                    if (resume_page)
                    begin
                        s_d.resume_one = reg_wdata;
                    end
                    else if (!div_latch)
                    begin
                        if (enh_func_en)
                        begin
                            s_d.modem_ctl = reg_wdata;
                        end
                        else
                        begin
                            // locked bits keep their value
                            s_d.modem_ctl = (reg_wdata & ~`ULMCS_MC_ENH_MASK)
                                          | (s_q.modem_ctl & `ULMCS_MC_ENH_MASK);
                        end
                    end
                end
                `ULMCS_OFF_LINE_STAT:
                begin
                    // line status is read only; only the resume page takes it
                    if (resume_page)
                    begin
                        s_d.resume_two = reg_wdata;
                    end
                end
                default:
                begin
                    s_d.line_fmt = s_q.line_fmt;
                end
            endcase
        end

        // overrun: a new event wins over the clearing read
        s_d.overrun = (rx_accept && fifo_full) || (s_q.overrun && !lsr_read);

        // fifo error tags follow the characters
        if (push)
        begin
            s_d.err_mem[s_q.wr_ptr] = rx_char_err;
            s_d.wr_ptr              = s_q.wr_ptr + 6'h01;
        end
        if (pop)
        begin
            s_d.rd_ptr = s_q.rd_ptr + 6'h01;
        end
        s_d.count     = s_q.count + {6'h00, push} - {6'h00, pop};
        s_d.err_count = s_q.err_count
                      + {6'h00, push && (rx_char_err != 3'h0)}
                      - {6'h00, pop && (s_q.err_mem[s_q.rd_ptr] != 3'h0)};

        // line status built from the new fifo state
        s_d.line_stat[7]   = (s_d.err_count != 7'h00);
        s_d.line_stat[6]   = !thr_full && !tsr_busy;
        s_d.line_stat[5]   = !thr_full;
        s_d.line_stat[4:2] = (s_d.count != 7'h00) ?
                             s_d.err_mem[s_d.rd_ptr] : 3'h0;
        s_d.line_stat[1]   = s_d.overrun;
        s_d.line_stat[0]   = (s_d.count != 7'h00);

        // read data, answered one cycle after the strobe
        if (reg_rd)
        begin
            case (reg_addr)
                `ULMCS_OFF_LINE_FMT:
                begin
                    s_d.rdata = s_q.line_fmt;
                end
                `ULMCS_OFF_MODEM_CTL:
                begin
                    s_d.rdata = resume_page ? s_q.resume_one :
                                div_latch   ? 8'h00 : s_q.modem_ctl;
                end
                `ULMCS_OFF_LINE_STAT:
                begin
                    s_d.rdata = resume_page ? s_q.resume_two :
                                div_latch   ? 8'h00 : s_q.line_stat;
                end
                default:
                begin
                    s_d.rdata = 8'h00;
                end
            endcase
        end

        // with resume-any set, any received character restarts a halted transmitter
        s_d.tx_resume = s_q.modem_ctl[`ULMCS_MC_RESUME_ANY] && rx_char_valid;

        // loopback feeds the encoder back into the decoder
        s_d.rx_serial = loopback ? tx_serial : s_q.rx_stable;

        // pins: control bit set drives the pin low
        if (loopback)
        begin
            s_d.send_req_n = 1'b1;
        end
        else if (auto_rts_en)
        begin
            s_d.send_req_n = auto_rts_n;
        end
        else
        begin
            s_d.send_req_n = !s_q.modem_ctl[`ULMCS_MC_SEND_REQ];
        end
        s_d.term_rdy_n = (dtr_pin_sel && !loopback) ?
                         !s_q.modem_ctl[`ULMCS_MC_TERM_RDY] : 1'b1;

        // modem status seen internally during loopback
        s_d.msr_loop = loopback ? {s_q.modem_ctl[`ULMCS_MC_AUX_TWO],
                                   s_q.modem_ctl[`ULMCS_MC_AUX_ONE],
                                   s_q.modem_ctl[`ULMCS_MC_TERM_RDY],
                                   s_q.modem_ctl[`ULMCS_MC_SEND_REQ]}
                                : 4'h0;
        s_d.alt_sel = s_q.modem_ctl[`ULMCS_MC_AUX_ONE] && !loopback;

        // prescaler: every clock, or one clock in four
        if (s_q.modem_ctl[`ULMCS_MC_PRESCALE])
        begin
            s_d.prescale = s_q.prescale + 2'h1;
            s_d.baud_en  = (s_q.prescale == `ULMCS_PRESCALE_LAST);
        end
        else
        begin
            s_d.prescale = 2'h0;
            s_d.baud_en  = 1'b1;
        end

        // character format decode
        s_d.data_bits = `ULMCS_WLEN_BASE + {2'h0, s_q.line_fmt[1:0]};
        if (!s_q.line_fmt[`ULMCS_LF_STOP])
        begin
            s_d.stop_halves = `ULMCS_STOP_ONE;
        end
        else if (s_q.line_fmt[1:0] == `ULMCS_WLEN_FIVE)
        begin
            s_d.stop_halves = `ULMCS_STOP_ONE_HALF;
        end
        else
        begin
            s_d.stop_halves = `ULMCS_STOP_TWO;
        end
    end

    // ==========================================================
    // state register; core reset spares the resume characters
    always_ff @(posedge clock)
    begin
        if (por_rst)
        begin
            s_q <= s_rst;
        end
        else if (srst)
        begin
            s_q            <= s_rst;
            s_q.resume_one <= s_q.resume_one;
            s_q.resume_two <= s_q.resume_two;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs straight from the state register
    assign reg_rdata   = s_q.rdata;
    assign send_req_n  = s_q.send_req_n;
    assign term_rdy_n  = s_q.term_rdy_n;
    assign rx_serial   = s_q.rx_serial;
    assign tx_resume   = s_q.tx_resume;
    assign infrared_en = s_q.modem_ctl[`ULMCS_MC_INFRARED];
    assign baud_en     = s_q.baud_en;
    assign msr_loop    = s_q.msr_loop;
    assign alt_sel     = s_q.alt_sel;
    assign data_bits   = s_q.data_bits;
    assign stop_halves = s_q.stop_halves;
    assign line_stat   = s_q.line_stat;
    assign resume_one  = s_q.resume_one;
    assign resume_two  = s_q.resume_two;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst || por_rst);

    a_word_len_decode: assert property (
        1'b1 |=> data_bits == `ULMCS_WLEN_BASE + {2'h0, $past(s_q.line_fmt[1:0])})
        else $error("word length decode wrong");

    a_stop_len_decode: assert property (
        s_q.line_fmt[2] && s_q.line_fmt[1:0] == 2'h0 |=> stop_halves == 3'h3)
        else $error("stop length for five bits wrong");

    a_mcr_enh_lock: assert property (
        reg_wr && !enh_func_en && reg_addr == `ULMCS_OFF_MODEM_CTL && !div_latch
        |=> (s_q.modem_ctl & `ULMCS_MC_ENH_MASK)
            == ($past(s_q.modem_ctl) & `ULMCS_MC_ENH_MASK))
        else $error("locked control bits changed");

    a_mcr_latch_hide: assert property (
        div_latch && !resume_page |=> $stable(s_q.modem_ctl))
        else $error("control written while latch enabled");

    a_overrun_flag: assert property (
        rx_accept && fifo_full && !rx_pop |=> s_q.count == `ULMCS_FIFO_DEPTH && line_stat[1])
        else $error("overrun not flagged or character stored");

    a_data_ready: assert property (
        s_q.count != 7'h00 && !rx_pop |=> line_stat[0])
        else $error("data ready missing");

    a_loop_rx_path: assert property (
        s_q.modem_ctl[4] |=> rx_serial == $past(tx_serial))
        else $error("loopback path broken");

    a_send_req_pin: assert property (
        !loopback && !auto_rts_en |=> send_req_n == !$past(s_q.modem_ctl[1]))
        else $error("send-request pin wrong");

    a_resume_pulse: assert property (
        s_q.modem_ctl[5] && rx_char_valid |=> tx_resume)
        else $error("resume pulse missing");

    a_prescale_gap: assert property (
        s_q.modem_ctl[7] && baud_en && $past(s_q.modem_ctl[7]) |=> !baud_en)
        else $error("prescaler not dividing");

endmodule : ulmcs_top

// file: inc/ulmcs_params.svh
// constants for the uart line, modem control and status block
// assumes inclusion by the package and by the block's single design file
`ifndef ULMCS_PARAMS_SVH
`define ULMCS_PARAMS_SVH
// ==========================================================
// register offsets
`define ULMCS_OFF_LINE_FMT   3'h3
`define ULMCS_OFF_MODEM_CTL  3'h4
`define ULMCS_OFF_LINE_STAT  3'h5
`define ULMCS_OFF_RESUME_1   3'h4
`define ULMCS_OFF_RESUME_2   3'h5
// ==========================================================
// reset values
`define ULMCS_LINE_FMT_RST   8'h1d
`define ULMCS_MODEM_CTL_RST  8'h00
`define ULMCS_LINE_STAT_RST  8'h60
`define ULMCS_RESUME_RST     8'h00
`define ULMCS_RESUME_KEY     8'hbf
// ==========================================================
// field positions
`define ULMCS_LF_DIV_LATCH   7
`define ULMCS_LF_STOP        2
`define ULMCS_MC_PRESCALE    7
`define ULMCS_MC_INFRARED    6
`define ULMCS_MC_RESUME_ANY  5
`define ULMCS_MC_LOOPBACK    4
`define ULMCS_MC_AUX_TWO     3
`define ULMCS_MC_AUX_ONE     2
`define ULMCS_MC_SEND_REQ    1
`define ULMCS_MC_TERM_RDY    0
// bits that only change while enhanced functions are enabled
`define ULMCS_MC_ENH_MASK    8'hec
// ==========================================================
// character format and receive fifo sizing
`define ULMCS_WLEN_BASE      4'h5
`define ULMCS_WLEN_FIVE      2'h0
`define ULMCS_STOP_ONE       3'h2
`define ULMCS_STOP_ONE_HALF  3'h3
`define ULMCS_STOP_TWO       3'h4
`define ULMCS_FIFO_DEPTH     7'h40
`define ULMCS_PRESCALE_LAST  2'h3
`endif

// file: inc/ulmcs_pkg.sv
// types for the uart line, modem control and status block
// assumes the constants header sits beside it
`include "ulmcs_params.svh"
package ulmcs_pkg;
    // ==========================================================
    // complete state of the block
    typedef struct packed {
        logic [7:0]       line_fmt;     // line_format_reg
        logic [7:0]       modem_ctl;    // modem_control_reg
        logic [7:0]       resume_one;   // resume_char_one
        logic [7:0]       resume_two;   // resume_char_two
        logic             overrun;      // sticky overrun flag
        logic [5:0]       wr_ptr;       // fifo error-tag write index
        logic [5:0]       rd_ptr;       // fifo error-tag read index
        logic [6:0]       count;        // characters held in rx fifo
        logic [6:0]       err_count;    // held characters with errors
        logic [63:0][2:0] err_mem;      // {break, framing, parity}
        logic [1:0]       prescale;     // divide-by-four counter
        logic             sync1;        // rx pin sync stage 1
        logic             sync2;        // rx pin sync stage 2
        logic             sync3;        // rx pin sync stage 3
        logic             rx_stable;    // filtered rx pin level
        logic [7:0]       rdata;        // register read data
        logic [7:0]       line_stat;    // line_status_reg
        logic             send_req_n;   // send-request pin level
        logic             term_rdy_n;   // terminal-ready pin level
        logic             rx_serial;    // line into the decoder
        logic             tx_resume;    // resume pulse
        logic             baud_en;      // baud generator enable
        logic [3:0]       msr_loop;     // {cd, bell, dsr, cts} loop
        logic             alt_sel;      // alternate page at 6/7
        logic [3:0]       data_bits;    // bits per character
        logic [2:0]       stop_halves;  // stop length in half bits
    } ulmcs_state_t;
endpackage : ulmcs_pkg

// file: verif/ulmcs_far_end.sv
// far-end model: a remote transmitter that hands characters to the block
// assumes the bench calls send from its own process on the core clock
module ulmcs_far_end
(
    input  wire logic       clock,
    output logic            rx_char_valid, // one pulse per character
    output logic      [2:0] rx_char_err,   // {break, framing, parity}
    output logic            rx_flow_char,  // character is a flow char
    output logic            rx_pin         // serial line, idles high
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // line idle and no character at time zero
    initial
    begin
        rx_char_valid = 1'b0;
        rx_char_err   = 3'h0;
        rx_flow_char  = 1'b0;
        rx_pin        = 1'b1;
    end
    // ==========================================================
    // deliver one character with its error tag
    task automatic send(input logic [2:0] e, input logic f);
        @(posedge clock);
        rx_char_valid <= 1'b1;
        rx_char_err   <= e;
        rx_flow_char  <= f;    // flow-character mark rides with the pulse
        @(posedge clock);
        rx_char_valid <= 1'b0;
        rx_char_err   <= ~e;   // tag invalid outside the pulse, so flip it
        rx_flow_char  <= 1'b0;
    endtask : send
    // ==========================================================
    // move the serial pin to a new level
    task automatic line(input logic v);
        @(posedge clock);
        rx_pin <= v;
    endtask : line
endmodule : ulmcs_far_end

// file: verif/tb_ulmcs_top.sv
// testbench: register port tasks and character events against expectations
// assumes the far-end model file and the package are compiled first
module tb_ulmcs_top
    import ulmcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
    // ==========================================================
    // stimulus and observed signals
    logic clock = 1'b0, srst = 1'b1, por_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, line_stat, resume_one, resume_two, d;
    logic enh_func_en = 1'b0, extra_page_sel = 1'b0, rx_pop = 1'b0, thr_full = 1'b0;
    logic tsr_busy = 1'b0, tx_serial = 1'b1, auto_rts_en = 1'b0, auto_rts_n = 1'b1;
    logic dtr_pin_sel = 1'b1, rx_swflow_en = 1'b0;
    logic rx_char_valid, rx_flow_char, rx_pin, send_req_n, term_rdy_n, rx_serial;
    logic tx_resume, infrared_en, baud_en, alt_sel;
    logic [2:0] rx_char_err, stop_halves;
    logic [3:0] msr_loop, data_bits, n;
    int         errors = 0, checked = 0;
    // 10 MHz core clock
    always #50 clock = ~clock;
    // ==========================================================
    ulmcs_top uut (.clock, .srst, .por_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .enh_func_en, .extra_page_sel, .rx_char_valid, .rx_char_err,
        .rx_flow_char, .rx_swflow_en, .rx_pop, .thr_full, .tsr_busy, .tx_serial, .rx_pin,
        .auto_rts_en, .auto_rts_n, .dtr_pin_sel, .send_req_n, .term_rdy_n, .rx_serial,
        .tx_resume, .infrared_en, .baud_en, .msr_loop, .alt_sel, .data_bits, .stop_halves,
        .line_stat, .resume_one, .resume_two);
    ulmcs_far_end far (.clock, .rx_char_valid, .rx_char_err, .rx_flow_char, .rx_pin);
    // ==========================================================
    // register port and fifo helpers
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask : tick
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : wr
    // read data is registered at the taking edge, picked up one edge later
    task automatic rd(input logic [2:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        @(posedge clock);
        d = reg_rdata;
    endtask : rd
    task automatic pop();
        @(posedge clock);
        rx_pop <= 1'b1;
        @(posedge clock);
        rx_pop <= 1'b0;
    endtask : pop
    // ==========================================================
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // watchdog, far beyond the several hundred cycles of the sequence
    initial
    begin
        tick(20000);
        errors++;
        summarize();
    end
    // ==========================================================
    // main sequence
    initial
    begin
        tick(5);
        srst    <= 1'b0;
        por_rst <= 1'b0;
        rd(3'h4); `CHK("modem_control reset", 8'h00, d)
        wr(3'h5, 8'hff); rd(3'h5); `CHK("line_status ro", 8'h60, d)
        for (int i = 0; i < 8; i++)
        begin
            wr(3'h3, {5'h00, i[2:0]}); tick(3);
            `CHK("data_bits", 4'h5 + {2'h0, i[1:0]}, data_bits)
            `CHK("stop_halves", i[2] ? (i[1:0] == 2'h0 ? 3'h3 : 3'h4) : 3'h2, stop_halves)
        end
        wr(3'h4, 8'hff); rd(3'h4); `CHK("modem_control gated", 8'h13, d)
        enh_func_en <= 1'b1;
        wr(3'h4, 8'h1f); tick(3); `CHK("loop status", 4'hf, msr_loop)
        wr(3'h4, 8'h1a); tick(3); `CHK("loop status", 4'h9, msr_loop)
        tx_serial <= 1'b0; tick(4); `CHK("loop line", 1'b0, rx_serial)
        tx_serial <= 1'b1;
        wr(3'h4, 8'h0c); tick(3); `CHK("alt select", 1'b1, alt_sel)
        `CHK("no loop status", 4'h0, msr_loop)
        // outside loopback the synchronised pin reaches the decoder
        far.line(1'b0); tick(6); `CHK("pin path", 1'b0, rx_serial)
        far.line(1'b1);
        wr(3'h4, 8'h03); tick(3); `CHK("send request", 1'b0, send_req_n)
        `CHK("terminal ready", 1'b0, term_rdy_n)
        auto_rts_en <= 1'b1; tick(3); `CHK("auto send request", 1'b1, send_req_n)
        auto_rts_en <= 1'b0;
        dtr_pin_sel <= 1'b0; tick(3); `CHK("terminal unassigned", 1'b1, term_rdy_n)
        dtr_pin_sel <= 1'b1;
        // baud enables counted over eight cycles, divided and undivided
        for (int p = 0; p < 2; p++)
        begin
            wr(3'h4, p == 0 ? 8'h80 : 8'h00); tick(3);
            n = 4'h0;
            repeat (8) @(posedge clock) n = n + {3'h0, baud_en};
            `CHK("baud enables", p == 0 ? 4'h2 : 4'h8, n)
        end
        wr(3'h4, 8'h40); tick(3); `CHK("infrared", 1'b1, infrared_en)
        // resume pulse only with resume-any set; character still stored
        for (int p = 0; p < 2; p++)
        begin
            wr(3'h4, p == 0 ? 8'h20 : 8'h00);
            far.send(3'h0, 1'b0);
            n = 4'h0;
            repeat (6) @(posedge clock) n = n + {3'h0, tx_resume};
            `CHK("resume pulses", p == 0 ? 4'h1 : 4'h0, n)
            `CHK("data ready", 8'h61, line_stat)
            pop(); tick(4);
        end
        // a flow character under soft flow control resumes but is not stored
        rx_swflow_en <= 1'b1; wr(3'h4, 8'h20); far.send(3'h0, 1'b1); n = 4'h0;
        repeat (6) @(posedge clock) n = n + {3'h0, tx_resume};
        `CHK("flow resume", 4'h1, n)
        `CHK("flow dropped", 8'h60, line_stat)
        rx_swflow_en <= 1'b0;
        // head character error flags, one kind at a time
        for (int e = 1; e < 8; e = e * 2)
        begin
            far.send(e[2:0], 1'b0); tick(4);
            rd(3'h5); `CHK("error flags", 8'he1 | {3'h0, e[2:0], 2'h0}, d)
            pop(); tick(4); `CHK("flags cleared", 8'h60, line_stat)
        end
        repeat (65) far.send(3'h0, 1'b0);
        tick(4); rd(3'h5); `CHK("overrun", 8'h63, d)
        rd(3'h5); `CHK("overrun read clear", 8'h61, d)
        repeat (64) pop();
        tick(4); `CHK("extra not stored", 8'h60, line_stat)
        thr_full <= 1'b1; tick(3); `CHK("holding full", 8'h00, line_stat)
        thr_full <= 1'b0;
        tsr_busy <= 1'b1; tick(3); `CHK("shift busy", 8'h20, line_stat)
        tsr_busy <= 1'b0;
        // resume characters: page access, srst survival, power-on clear
        wr(3'h3, 8'hbf); wr(3'h4, 8'ha5); wr(3'h5, 8'h5a);
        rd(3'h4); `CHK("resume one", 8'ha5, d)
        rd(3'h5); `CHK("resume two", 8'h5a, d)
        extra_page_sel <= 1'b1; rd(3'h4); `CHK("page hidden", 8'h00, d)
        extra_page_sel <= 1'b0;
        wr(3'h3, 8'h9f); wr(3'h4, 8'h55); rd(3'h5); `CHK("latch hides status", 8'h00, d)
        wr(3'h3, 8'h03); rd(3'h4); `CHK("latch drops write", 8'h20, d)
        srst <= 1'b1; tick(2); srst <= 1'b0; tick(2);
        `CHK("resume kept", 8'ha5, resume_one)
        rd(3'h4); `CHK("modem_control srst", 8'h00, d)
        por_rst <= 1'b1; tick(2); por_rst <= 1'b0; tick(2);
        `CHK("resume cleared", 8'h00, resume_two)
        summarize();
    end
endmodule : tb_ulmcs_top
